//--- inc/raoc_cfg.svh
// register map, field positions and slot bit counts of the receiver audio output block
`ifndef RAOC_CFG_SVH
`define RAOC_CFG_SVH
`define RAOC_ADDR_FORMAT 8'h44
`define RAOC_ADDR_MODE 8'h4a
`define RAOC_RST_FORMAT 8'h00
`define RAOC_RST_MODE 8'h00
`define RAOC_MASK_FORMAT 8'h7f
`define RAOC_MASK_MODE 8'hb4
`define RAOC_MODE_PWRDN 7
`define RAOC_MODE_RFRX 5
`define RAOC_MODE_REQPOL 4
`define RAOC_MODE_SPDIF 2
`define RAOC_FMT_DATA 6
`define RAOC_FMT_SIZE 5:4
`define RAOC_FMT_WSPOL 3
`define RAOC_FMT_EDGE 2
`define RAOC_FMT_DELAY 1
`define RAOC_FMT_JUST 0
`define RAOC_SIZE_24 2'h2
`define RAOC_BITS_16 6'h10
`define RAOC_BITS_24 6'h18
`define RAOC_SLOT_BITS 6'h20
`endif

//--- inc/raoc_pkg.sv
// shared types of the receiver audio output block
package raoc_pkg;
    typedef enum logic [0:0] {HS_IDLE, HS_BUSY} raoc_hs_t;
endpackage

//--- rtl/raoc_i2s_ser.sv
// i2s frame serializer running on the audio link clock
`timescale 1ns/1ps
`include "raoc_cfg.svh"
module raoc_i2s_ser #(
    parameter int SAMPLE_W = 24
) (
    input wire logic i_aclk,
    input wire logic i_rstn,
    input wire logic i_run,
    input wire logic i_edge,
    input wire logic i_wspol,
    input wire logic i_delay0,
    input wire logic i_just,
    input wire logic [1:0] i_size,
    input wire logic [SAMPLE_W-1:0] i_left,
    input wire logic [SAMPLE_W-1:0] i_right,
    output logic o_sck,
    output logic o_ws,
    output logic o_sd,
    output logic o_load
);
    logic sck_reg, sck_next, ws_reg, ws_next, sd_reg, sd_next, ch_reg, ch_next;
    logic [5:0] cnt_reg, cnt_next, off, len;
    logic [SAMPLE_W-1:0] sh_reg, sh_next, rh_reg, rh_next, src;
    logic launch, in_range, left_msb, go;

    // a stop with the clock high finishes that half cycle, so no bit is sampled twice
    assign go = i_run || sck_reg;
    // data moves on the edge opposite the one the dac samples on
    assign launch = go && (sck_reg != i_edge);
    // reserved size codes fall back to 16 bits rather than garbling the frame
    assign len = (i_size == `RAOC_SIZE_24) ? `RAOC_BITS_24 : `RAOC_BITS_16;
    assign off = i_just ? (`RAOC_SLOT_BITS - len) : {5'h00, ~i_delay0};
    assign in_range = (cnt_reg >= off) && (cnt_reg < off + len);
    assign src = (cnt_reg == 6'h00) ? (ch_reg ? rh_reg : i_left) : sh_reg;
    assign left_msb = i_left[SAMPLE_W-1];
    // combinational so the shadow owner sees the take in the same cycle
    assign o_load = launch && (cnt_reg == 6'h00) && !ch_reg;
    assign o_sck = sck_reg;
    assign o_ws = ws_reg;
    assign o_sd = sd_reg;

    // bit clock is half the link clock; a stop freezes it low mid-frame
    always_comb begin
        sck_next = go ? ~sck_reg : 1'b0;
        ws_next = ws_reg;
        sd_next = sd_reg;
        ch_next = ch_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        rh_next = rh_reg;
        if (launch) begin
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == `RAOC_SLOT_BITS - 6'h01) begin
                cnt_next = 6'h00;
                ch_next = ~ch_reg;
            end
            if (cnt_reg == 6'h00) begin
                ws_next = ch_reg ^ i_wspol;
                if (!ch_reg) begin
                    rh_next = i_right; // right word of the pair kept so it cannot tear
                end
            end
            sd_next = in_range ? src[SAMPLE_W-1] : 1'b0;
            sh_next = in_range ? (src << 1) : src;
        end
    end

    // serializer state
    always_ff @(posedge i_aclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sck_reg <= 1'b0;
            ws_reg <= 1'b0;
            sd_reg <= 1'b0;
            ch_reg <= 1'b0;
            cnt_reg <= 6'h00;
            sh_reg <= '0;
            rh_reg <= '0;
        end else begin
            sck_reg <= sck_next;
            ws_reg <= ws_next;
            sd_reg <= sd_next;
            ch_reg <= ch_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            rh_reg <= rh_next;
        end
    end

    default clocking @(posedge i_aclk); endclocking
    default disable iff (!i_rstn);

    AST_WS_POL: assert property (launch && cnt_reg == 6'h00
        |=> o_ws == ($past(ch_reg) ^ $past(i_wspol)))
        else $error("word select level does not match channel and polarity");
    AST_MSB_DELAY: assert property (launch && cnt_reg == 6'h00 && !i_just && !i_delay0
        |=> !o_sd)
        else $error("msb not delayed by one bit clock");
    AST_NO_DELAY: assert property (launch && cnt_reg == 6'h00 && !ch_reg && !i_just && i_delay0
        |=> o_sd == $past(left_msb))
        else $error("msb missing in the word select slot with no delay");
    AST_SIZE16_TAIL: assert property (launch && !i_just && i_size != `RAOC_SIZE_24
        && cnt_reg > `RAOC_BITS_16 |=> !o_sd)
        else $error("16-bit word runs past its length");
    AST_EDGE_ALIGN: assert property ($changed(o_sd) || $changed(o_ws) |-> $past(launch))
        else $error("data or word select moved off the launch edge");
endmodule

//--- rtl/raoc_top.sv
// receiver audio output control: registers, pacing and i2s output
`timescale 1ns/1ps
`include "raoc_cfg.svh"
// Function
// - mode register: powerdown, rf enable, polarity, spdif
// - format register: size, edge, justification, resets zero
// - word select polarity picks which level means left
// - delay bit: one bit clock or none
// - data mode: halt outputs once request goes inactive
// - data mode: resume outputs when request returns active
// - registers reachable by linked transmitter from reset
// - output framing follows standard i2s
// - polarity bit clear means request active low
module raoc_top #(
    parameter int SAMPLE_W = 24
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_aclk,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_ack,
    input wire logic i_smp_valid,
    input wire logic [SAMPLE_W-1:0] i_smp_left,
    input wire logic [SAMPLE_W-1:0] i_smp_right,
    output logic o_smp_ready,
    input wire logic i_req,
    output logic o_pwrdn,
    output logic o_rf_rx_en,
    output logic o_spdif_sel,
    output logic o_i2s_sck,
    output logic o_i2s_ws,
    output logic o_i2s_sd
);
    logic [7:0] mode_reg, mode_next, fmt_reg, fmt_next, rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    raoc_pkg::raoc_hs_t hs_reg, hs_next;
    logic [SAMPLE_W-1:0] hold_l_reg, hold_l_next, hold_r_reg, hold_r_next;
    logic tgl_reg, tgl_next, ready_reg, ready_next, ack_s1_reg, ack_s2_reg;
    logic lrst_s1_reg, lrstn_reg;
    logic [15:0] cfg_s1_reg, cfg_s2_reg;
    logic [7:0] l_mode, l_fmt;
    logic rq_s1_reg, rq_s2_reg, req_s1_reg, req_s2_reg, req_act;
    logic ltgl_reg, ltgl_next, full_reg, full_next, run_reg, run_next, ser_load;
    logic [SAMPLE_W-1:0] shad_l_reg, shad_l_next, shad_r_reg, shad_r_next;

    // configuration pins come straight from the register flops
    assign o_pwrdn = mode_reg[`RAOC_MODE_PWRDN];
    assign o_rf_rx_en = mode_reg[`RAOC_MODE_RFRX];
    assign o_spdif_sel = mode_reg[`RAOC_MODE_SPDIF];
    assign o_reg_rdata = rdata_reg;
    assign o_reg_ack = ack_reg;
    assign o_smp_ready = ready_reg;

    // register port fed by the radio control channel; reserved bits are dropped
    always_comb begin
        mode_next = mode_reg;
        fmt_next = fmt_reg;
        rdata_next = 8'h00;
        ack_next = i_reg_wr || i_reg_rd;
        if (i_reg_wr && i_reg_addr == `RAOC_ADDR_MODE) begin
            mode_next = i_reg_wdata & `RAOC_MASK_MODE;
        end
        if (i_reg_wr && i_reg_addr == `RAOC_ADDR_FORMAT) begin
            fmt_next = i_reg_wdata & `RAOC_MASK_FORMAT;
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                `RAOC_ADDR_MODE: rdata_next = mode_reg;
                `RAOC_ADDR_FORMAT: rdata_next = fmt_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // register state, zero from reset so the link can reach it at once
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_reg <= `RAOC_RST_MODE;
            fmt_reg <= `RAOC_RST_FORMAT;
            rdata_reg <= 8'h00;
            ack_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            fmt_reg <= fmt_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
        end
    end

    // sample intake: one pair held until the link side acknowledges it
    always_comb begin
        hs_next = hs_reg;
        hold_l_next = hold_l_reg;
        hold_r_next = hold_r_reg;
        tgl_next = tgl_reg;
        ready_next = ready_reg;
        case (hs_reg)
            raoc_pkg::HS_IDLE: begin
                ready_next = 1'b1;
                if (i_smp_valid && ready_reg) begin
                    hold_l_next = i_smp_left;
                    hold_r_next = i_smp_right;
                    tgl_next = ~tgl_reg;
                    ready_next = 1'b0;
                    hs_next = raoc_pkg::HS_BUSY;
                end
            end
            raoc_pkg::HS_BUSY: begin
                if (ack_s2_reg == tgl_reg) begin
                    ready_next = 1'b1;
                    hs_next = raoc_pkg::HS_IDLE;
                end
            end
            default: begin
                ready_next = 1'b0;
                hs_next = raoc_pkg::HS_IDLE;
            end
        endcase
    end

    // intake state plus the two-flop return path of the link acknowledge
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hs_reg <= raoc_pkg::HS_IDLE;
            hold_l_reg <= '0;
            hold_r_reg <= '0;
            tgl_reg <= 1'b0;
            ready_reg <= 1'b0;
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            hs_reg <= hs_next;
            hold_l_reg <= hold_l_next;
            hold_r_reg <= hold_r_next;
            tgl_reg <= tgl_next;
            ready_reg <= ready_next;
            ack_s1_reg <= ltgl_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    // link reset: asserts at once, releases on the link clock
    always_ff @(posedge i_aclk or negedge i_rstn) begin
        if (!i_rstn) begin
            lrst_s1_reg <= 1'b0;
            lrstn_reg <= 1'b0;
        end else begin
            lrst_s1_reg <= 1'b1;
            lrstn_reg <= lrst_s1_reg;
        end
    end

    // two-flop synchronisers into the link domain; configuration is
    // quasi-static, so a write may show one mixed frame while it settles
    always_ff @(posedge i_aclk or negedge lrstn_reg) begin
        if (!lrstn_reg) begin
            cfg_s1_reg <= {`RAOC_RST_MODE, `RAOC_RST_FORMAT};
            cfg_s2_reg <= {`RAOC_RST_MODE, `RAOC_RST_FORMAT};
            rq_s1_reg <= 1'b0;
            rq_s2_reg <= 1'b0;
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
        end else begin
            cfg_s1_reg <= {mode_reg, fmt_reg};
            cfg_s2_reg <= cfg_s1_reg;
            rq_s1_reg <= tgl_reg;
            rq_s2_reg <= rq_s1_reg;
            req_s1_reg <= i_req;
            req_s2_reg <= req_s1_reg;
        end
    end

    assign l_mode = cfg_s2_reg[15:8];
    assign l_fmt = cfg_s2_reg[7:0];
    // polarity bit gives the active level of the pacing request
    assign req_act = (req_s2_reg == l_mode[`RAOC_MODE_REQPOL]);

    // shadow pair for the serializer; a full shadow stalls the intake
    always_comb begin
        ltgl_next = ltgl_reg;
        shad_l_next = shad_l_reg;
        shad_r_next = shad_r_reg;
        full_next = full_reg;
        if (ser_load) begin
            full_next = 1'b0;
        end
        if (rq_s2_reg != ltgl_reg && !full_reg) begin
            shad_l_next = hold_l_reg;
            shad_r_next = hold_r_reg;
            ltgl_next = rq_s2_reg;
            full_next = 1'b1;
        end
        // request only paces data mode; powerdown always stops the port
        run_next = !l_mode[`RAOC_MODE_PWRDN] && (!l_fmt[`RAOC_FMT_DATA] || req_act);
    end

    // link-side state
    always_ff @(posedge i_aclk or negedge lrstn_reg) begin
        if (!lrstn_reg) begin
            ltgl_reg <= 1'b0;
            shad_l_reg <= '0;
            shad_r_reg <= '0;
            full_reg <= 1'b0;
            run_reg <= 1'b0;
        end else begin
            ltgl_reg <= ltgl_next;
            shad_l_reg <= shad_l_next;
            shad_r_reg <= shad_r_next;
            full_reg <= full_next;
            run_reg <= run_next;
        end
    end

    // an empty shadow at frame start simply replays the last pair
    raoc_i2s_ser #(
        .SAMPLE_W(SAMPLE_W)
    ) u_ser (
        .i_aclk(i_aclk),
        .i_rstn(lrstn_reg),
        .i_run(run_reg),
        .i_edge(l_fmt[`RAOC_FMT_EDGE]),
        .i_wspol(l_fmt[`RAOC_FMT_WSPOL]),
        .i_delay0(l_fmt[`RAOC_FMT_DELAY]),
        .i_just(l_fmt[`RAOC_FMT_JUST]),
        .i_size(l_fmt[`RAOC_FMT_SIZE]),
        .i_left(shad_l_reg),
        .i_right(shad_r_reg),
        .o_sck(o_i2s_sck),
        .o_ws(o_i2s_ws),
        .o_sd(o_i2s_sd),
        .o_load(ser_load)
    );

    AST_MODE_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_reg_wr && i_reg_addr == `RAOC_ADDR_MODE
        |=> mode_reg == ($past(i_reg_wdata) & `RAOC_MASK_MODE))
        else $error("mode register did not take the written value");
    AST_FMT_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_reg_wr && i_reg_addr == `RAOC_ADDR_FORMAT
        |=> fmt_reg == ($past(i_reg_wdata) & `RAOC_MASK_FORMAT))
        else $error("format register did not take the written value");
    AST_READBACK: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_reg_rd && !i_reg_wr && i_reg_addr == `RAOC_ADDR_MODE
        |=> o_reg_ack && o_reg_rdata == mode_reg)
        else $error("mode register read back wrong");
    AST_HALT_FAST: assert property (@(posedge i_aclk) disable iff (!lrstn_reg)
        l_fmt[`RAOC_FMT_DATA] && !req_act |=> !run_reg ##1 !o_i2s_sck)
        else $error("port not halted after request went inactive");
    AST_STALL_FROZEN: assert property (@(posedge i_aclk) disable iff (!lrstn_reg)
        !run_reg && !o_i2s_sck |=> !o_i2s_sck && $stable(o_i2s_ws) && $stable(o_i2s_sd))
        else $error("outputs moved while halted");
    AST_RESUME: assert property (@(posedge i_aclk) disable iff (!lrstn_reg)
        (!l_mode[`RAOC_MODE_PWRDN] && req_act)[*2] |=> o_i2s_sck != $past(o_i2s_sck))
        else $error("bit clock did not resume with active request");
    AST_POL_LOW: assert property (@(posedge i_aclk) disable iff (!lrstn_reg)
        !l_mode[`RAOC_MODE_REQPOL] && !req_s2_reg && !l_mode[`RAOC_MODE_PWRDN] |=> run_reg)
        else $error("low request not taken as active with polarity clear");

    COV_HALT: cover property (@(posedge i_aclk) disable iff (!lrstn_reg) run_reg ##1 !run_reg);
    COV_RESUME: cover property (@(posedge i_aclk) disable iff (!lrstn_reg)
        !run_reg && l_fmt[`RAOC_FMT_DATA] ##1 run_reg);
    COV_SAMPLE: cover property (@(posedge i_clk) disable iff (!i_rstn)
        i_smp_valid && o_smp_ready ##[1:400] o_smp_ready);
endmodule

//--- test/raoc_dac_model.sv
// behavioural i2s dac that deserializes the output slots
`timescale 1ns/1ps
module raoc_dac_model (
    input wire logic i_sck,
    input wire logic i_ws,
    input wire logic i_sd,
    input wire logic i_fall,
    input wire logic i_wspol,
    output logic [31:0] o_left,
    output logic [31:0] o_right,
    output int o_frames,
    output int o_bad
);
    logic [31:0] shreg = 32'h0;
    logic last_ws = 1'b0;
    int nbits = 0;
    initial begin
        o_left = 32'h0;
        o_right = 32'h0;
        o_frames = 0;
        o_bad = 0;
    end
    // sample on the valid edge only; a ws change closes the slot just shifted in
    always @(i_sck) begin
        if (i_sck === ~i_fall) begin
            if (i_ws !== last_ws) begin
                if (nbits != 32) o_bad++;
                if ((last_ws ^ i_wspol) == 1'b0) o_left = shreg;
                else begin
                    o_right = shreg;
                    o_frames++;
                end
                nbits = 0;
            end
            shreg = {shreg[30:0], i_sd};
            nbits++;
            last_ws = i_ws;
        end
    end
endmodule

//--- test/testbench.sv
// self-checking bench: registers, output formats and request pacing
`timescale 1ns/1ps
module testbench;
    logic i_clk = 1'b0;
    logic i_aclk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_smp_valid = 1'b0;
    logic [23:0] i_smp_left = 24'h000000;
    logic [23:0] i_smp_right = 24'h000000;
    logic i_req = 1'b0;
    logic fall_sel = 1'b0;
    logic ws_pol = 1'b0;
    logic [7:0] o_reg_rdata;
    logic o_reg_ack, o_smp_ready, o_pwrdn, o_rf_rx_en, o_spdif_sel;
    logic o_i2s_sck, o_i2s_ws, o_i2s_sd;
    logic [31:0] dac_left, dac_right;
    int frames, bad;
    int err_count = 0;
    int samples_checked = 0;
    int sck_edges = 0;
    logic [7:0] fmts [7] = '{8'h00, 8'h20, 8'h22, 8'h21, 8'h01, 8'h28, 8'h24};

    raoc_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_aclk(i_aclk), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .i_smp_valid(i_smp_valid),
        .i_smp_left(i_smp_left), .i_smp_right(i_smp_right), .o_smp_ready(o_smp_ready),
        .i_req(i_req), .o_pwrdn(o_pwrdn), .o_rf_rx_en(o_rf_rx_en),
        .o_spdif_sel(o_spdif_sel), .o_i2s_sck(o_i2s_sck), .o_i2s_ws(o_i2s_ws),
        .o_i2s_sd(o_i2s_sd));
    raoc_dac_model dac (.i_sck(o_i2s_sck), .i_ws(o_i2s_ws), .i_sd(o_i2s_sd),
        .i_fall(fall_sel), .i_wspol(ws_pol), .o_left(dac_left), .o_right(dac_right),
        .o_frames(frames), .o_bad(bad));

    // core clock, and a link clock offset so the two never line up
    always #12.5 i_clk = ~i_clk;
    initial begin
        #3.3;
        forever #80 i_aclk = ~i_aclk;
    end
    always @(o_i2s_sck) sck_edges++;

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop;
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // strobes are one-cycle pulses; ack and data stand only in the next cycle
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
        check("write ack", o_reg_ack, 1'b1);
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        check("read ack", o_reg_ack, 1'b1);
        check("read data", o_reg_rdata, e);
        @(negedge i_clk);
        check("read data released", o_reg_rdata, 8'h00);
    endtask

    task automatic test_regs;
        logic [7:0] m;
        reg_read(8'h44, 8'h00);
        reg_read(8'h4a, 8'h00);
        check("mode pins at reset", {o_pwrdn, o_rf_rx_en, o_spdif_sel}, 3'h0);
        reg_write(8'h4a, 8'hb4); // every defined bit set, reserved bits zero
        reg_read(8'h4a, 8'hb4);
        reg_write(8'h44, 8'h6f); // 24-bit code, reserved bit zero
        reg_read(8'h44, 8'h6f);
        reg_write(8'h10, 8'h55);
        reg_read(8'h10, 8'h00);
        reg_read(8'h4a, 8'hb4);
        // one control bit at a time so a swapped pin shows up
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? 8'h80 : (i == 1) ? 8'h20 : 8'h04;
            reg_write(8'h4a, m);
            check("mode pins", {o_pwrdn, o_rf_rx_en, o_spdif_sel}, {m[7], m[5], m[2]});
        end
        reg_write(8'h4a, 8'h00); // reserved bits written as zero
        reg_write(8'h44, 8'h00);
    endtask

    // ready is looked at on the falling edge, so the next rising edge takes the pair
    task automatic send_pair(input logic [23:0] l, input logic [23:0] r);
        int n;
        @(negedge i_clk);
        i_smp_valid = 1'b1;
        i_smp_left = l;
        i_smp_right = r;
        for (n = 0; n < 2000 && o_smp_ready !== 1'b1; n++) @(negedge i_clk);
        check("sample ready", o_smp_ready, 1'b1);
        @(negedge i_clk);
        i_smp_valid = 1'b0;
        check("ready drops after take", o_smp_ready, 1'b0);
    endtask

    task automatic wait_frames(input int n);
        int target;
        int k;
        target = frames + n;
        for (k = 0; k < 1200 * n && frames < target; k++) @(negedge i_clk);
        check("frames played", frames >= target, 1'b1);
    endtask

    function automatic logic [31:0] exp_slot(input logic [7:0] f, input logic [23:0] s);
        logic [23:0] w;
        w = (f[5:4] == 2'h2) ? s : {s[23:8], 8'h00};
        if (f[0]) return (f[5:4] == 2'h2) ? {8'h00, s} : {16'h0000, s[23:8]};
        return f[1] ? {w, 8'h00} : {1'b0, w, 7'h00};
    endfunction

    // two frames to settle the quasi-static config, then two judged frames
    task automatic fmt_case(input logic [7:0] f, input logic [23:0] l, input logic [23:0] r);
        int bad0;
        reg_write(8'h44, f);
        fall_sel = f[2];
        ws_pol = f[3];
        send_pair(l, r);
        wait_frames(2);
        bad0 = bad;
        wait_frames(2);
        check("left slot", dac_left, exp_slot(f, l));
        check("right slot", dac_right, exp_slot(f, r));
        check("slot length", bad - bad0, 32'h0);
    endtask

    // the halt bound is 32 bit clocks of 320 ns, about 410 core cycles
    task automatic halt_case(input logic [7:0] m, input logic req, input logic run);
        int e0;
        reg_write(8'h4a, m);
        @(negedge i_clk);
        i_req = req;
        repeat (420) @(negedge i_clk);
        e0 = sck_edges;
        repeat (100) @(negedge i_clk);
        check("bit clock running", sck_edges != e0, run);
    endtask

    // slots must stay whole across every halt, so no bit is lost or doubled
    task automatic test_pace;
        int bad0;
        reg_write(8'h44, 8'h40);
        fall_sel = 1'b0;
        ws_pol = 1'b0;
        wait_frames(2);
        bad0 = bad;
        halt_case(8'h00, 1'b0, 1'b1);
        halt_case(8'h00, 1'b1, 1'b0);
        halt_case(8'h00, 1'b0, 1'b1);
        halt_case(8'h10, 1'b0, 1'b0);
        halt_case(8'h10, 1'b1, 1'b1);
        halt_case(8'h90, 1'b1, 1'b0);
        halt_case(8'h10, 1'b1, 1'b1);
        wait_frames(2);
        check("slot length across halts", bad - bad0, 32'h0);
        check("left after halts", dac_left, exp_slot(8'h40, 24'h96c3ab));
        check("right after halts", dac_right, exp_slot(8'h40, 24'h5a0f36));
    endtask

    initial begin
        repeat (12) @(negedge i_clk);
        i_rstn = 1'b1;
        repeat (2) @(negedge i_clk);
        test_regs;
        for (int i = 0; i < 7; i++) fmt_case(fmts[i], 24'h96c3a5 + i, 24'h5a0f3c - i);
        test_pace;
        report_and_stop;
    end

    // watchdog well beyond the roughly 30k core cycles the run needs
    initial begin
        #2000000;
        err_count++;
        report_and_stop;
    end
endmodule
